// ---- verilog/monitor_regs_pkg.sv ----
// Shared constants and carriers for the monitor result and converter-code register bank
package monitor_regs_pkg;
  // Clock and refresh timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TEMP_REFRESH_MS = 5;
  localparam int TEMP_REFRESH_CYCLES = TEMP_REFRESH_MS * 1_000_000 / CLK_PERIOD_NS;

  // Bus window, byte addresses of 32-bit words
  localparam int WB_ADDR_W = 12;
  localparam logic [11:0] WB_POINTER_ADDR = 12'h100;
  localparam logic [11:0] WB_DATA_ADDR = 12'h104;
  localparam logic [11:0] WB_STATUS_ADDR = 12'h108;

  // Pointer and register indices behind the data port
  localparam int POINTER_SEL_W = 6;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [5:0] REG_COMMAND = 6'h00;
  localparam logic [5:0] REG_RESULT = 6'h01;
  localparam logic [5:0] REG_EXT_TEMP1 = 6'h02;
  localparam logic [5:0] REG_EXT_TEMP2 = 6'h03;
  localparam logic [5:0] REG_INT_TEMP = 6'h04;
  localparam logic [7:0] COMMAND_RESET = 8'h00;

  // Result word layout
  localparam int ALERT_BIT = 15;
  localparam int TAG_HI = 14;
  localparam int TAG_LO = 12;
  localparam int OPEN_BIT = 11;
  localparam int CODE_W = 12;
  localparam int TEMP_W = 11;
  localparam int ADC_CHANNELS = 6;
  localparam int DAC_CHANNELS = 4;
  localparam logic [2:0] TAG_EXT_TEMP1 = 3'h6;
  localparam logic [2:0] TAG_EXT_TEMP2 = 3'h7;

  // Status word fields
  localparam int STAT_PHASE_BIT = 0;
  localparam int STAT_CMD_MODE_BIT = 1;
  localparam int STAT_CURSOR_LO = 4;

  typedef struct packed {
    logic alert;
    logic [CODE_W-1:0] code;
  } adc_sample_s;

  typedef struct packed {
    logic alert;
    logic open_diode;
    logic [TEMP_W-1:0] code;
  } temp_sample_s;

  typedef struct packed {
    logic alert;
    logic [2:0] tag;
    logic [CODE_W-1:0] value;
  } result_word_s;
endpackage

// ---- verilog/temp_refresh_latch.sv ----
// Periodic capture of the three temperature readings
`timescale 1ns/1ns
module temp_refresh_latch
  import monitor_regs_pkg::*;
#(
  parameter int PERIOD_CYCLES = TEMP_REFRESH_CYCLES
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire temp_sample_s ext1_in,
  input wire temp_sample_s ext2_in,
  input wire temp_sample_s int_in,
  output temp_sample_s ext1_out,
  output temp_sample_s ext2_out,
  output temp_sample_s int_out,
  output logic refresh_out
);
  localparam int CNT_W = $clog2(PERIOD_CYCLES + 1);

  if (PERIOD_CYCLES < 2)
  begin : g_bad_period
    $error("temp_refresh_latch: PERIOD_CYCLES must be at least 2");
  end

  logic [CNT_W-1:0] count;
  wire tick = (count == CNT_W'(PERIOD_CYCLES - 1));

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      count <= '0;
      refresh_out <= 1'b0;
      ext1_out <= '0;
      ext2_out <= '0;
      int_out <= '0;
    end
    else
    begin
      count <= tick ? '0 : count + 1'b1;
      refresh_out <= tick;
      // Free-running: refresh needs no host request
      if (tick)
      begin
        ext1_out <= ext1_in;
        ext2_out <= ext2_in;
        int_out <= int_in;
      end
    end
  end
endmodule

// ---- verilog/dac_code_latch.sv ----
// Two-byte assembly of converter output codes
`timescale 1ns/1ns
module dac_code_latch
  import monitor_regs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic byte_we_in,
  input wire logic second_byte_in,
  input wire logic [1:0] channel_in,
  input wire logic [7:0] byte_in,
  output logic [DAC_CHANNELS-1:0][CODE_W-1:0] dac_code_out,
  output logic [DAC_CHANNELS-1:0] dac_update_out
);
  logic [3:0] pending_high;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      pending_high <= 4'h0;
      dac_code_out <= '0;
      dac_update_out <= '0;
    end
    else
    begin
      dac_update_out <= '0;
      if (byte_we_in && !second_byte_in)
      begin
        pending_high <= byte_in[3:0];
      end
      // Output moves only on a second-byte write, using the last held high nibble
      if (byte_we_in && second_byte_in)
      begin
        dac_code_out[channel_in] <= {pending_high, byte_in};
        dac_update_out[channel_in] <= 1'b1;
      end
    end
  end
endmodule

// ---- verilog/monitor_result_and_dac_regs.sv ----
// Result formatting, command sequencing and converter-code register bank on a Wishbone port
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Sixteen-bit read-only result register for six channels
// - Bits 14..12 carry channel tag
// - Bits 11..0 hold latest unsigned code
// - Bit 15 is alert indicator
// - Reads return high byte then low byte
// - Command bits select inputs, sense, temperatures
// - Tags: inputs 0-3, sense 4-5, temps 6-7
// - External temp word: alert, tag, open flag
// - Temperature in bits 10..0, two's complement
// - Temperatures refresh automatically about every 5 ms
// - Internal temp: alert bit 15, bits 14..11 zero
// - Bit 10 weighs -256, down to 0.25
// - Writes to 1..4 set converter codes A..D
// - Converter code is bits 11..0, rest ignored
// - Low six pointer bits select register
// - Each result read steps to next selected channel
// - Temperature selections replay last automatic result
module monitor_result_and_dac_regs
  import monitor_regs_pkg::*;
#(
  parameter int TEMP_PERIOD_CYCLES = TEMP_REFRESH_CYCLES
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [WB_ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire adc_sample_s [ADC_CHANNELS-1:0] adc_sample_in,
  input wire temp_sample_s ext_temp1_in,
  input wire temp_sample_s ext_temp2_in,
  input wire temp_sample_s int_temp_in,
  output logic [DAC_CHANNELS-1:0][CODE_W-1:0] dac_code_out,
  output logic [DAC_CHANNELS-1:0] dac_update_out,
  output logic temp_refresh_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // The refresh divider needs two states at least to form a one-cycle pulse
  if (TEMP_PERIOD_CYCLES < 2)
  begin : g_bad_period
    $error("monitor_result_and_dac_regs: TEMP_PERIOD_CYCLES must be at least 2");
  end
  // Three-bit positions must cover every converter channel plus two temperature slots
  if (ADC_CHANNELS + 2 > 8)
  begin : g_bad_channels
    $error("monitor_result_and_dac_regs: too many channels for a three-bit position");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Next set bit strictly after from, wrapping; from itself if none is set
  function automatic logic [2:0] next_selected(input logic [7:0] mask, input logic [2:0] from);
    logic [2:0] idx;
    logic found;
    next_selected = from;
    found = 1'b0;
    for (int k = 1; k <= 8; k++)
    begin
      idx = from + 3'(k);
      if (!found && mask[idx])
      begin
        next_selected = idx;
        found = 1'b1;
      end
    end
  endfunction

  // Temperature word; internal sensor clears tag and open flag
  function automatic logic [15:0] temp_word(input temp_sample_s s, input logic [2:0] tag, input logic ext);
    logic [15:0] w;
    w = '0;
    w[ALERT_BIT] = s.alert;
    w[TEMP_W-1:0] = s.code;
    if (ext)
    begin
      w[TAG_HI:TAG_LO] = tag;
      w[OPEN_BIT] = s.open_diode;
    end
    temp_word = w;
  endfunction

  // Status word: byte phase, command mode flag and sequence position
  function automatic logic [31:0] status_pack(input logic ph, input logic cmd_mode, input logic [2:0] pos);
    logic [31:0] s;
    s = '0;
    s[STAT_PHASE_BIT] = ph;
    s[STAT_CMD_MODE_BIT] = cmd_mode;
    s[STAT_CURSOR_LO +: 3] = pos;
    status_pack = s;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] pointer;
  logic [7:0] command;
  logic [2:0] cursor;
  logic phase;
  logic [15:0] shadow;
  logic [7:0] next_pointer;
  logic [7:0] next_command;
  logic [2:0] next_cursor;
  logic next_phase;
  logic [15:0] next_shadow;
  logic next_ack;
  logic [31:0] next_rdata;
  temp_sample_s ext1_held;
  temp_sample_s ext2_held;
  temp_sample_s int_held;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic req;
  logic hit_pointer;
  logic hit_data;
  logic hit_status;
  logic low_lane;
  logic pointer_wr;
  logic data_wr;
  logic data_rd;
  logic [7:0] wr_byte;
  logic [POINTER_SEL_W-1:0] target;
  logic at_command;
  logic at_result;
  logic at_dac;
  logic [1:0] dac_channel;

  // A held request is taken once; the ack cycle never starts a second access
  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign hit_pointer = (wb_adr_in == WB_POINTER_ADDR);
  assign hit_data = (wb_adr_in == WB_DATA_ADDR);
  assign hit_status = (wb_adr_in == WB_STATUS_ADDR);
  assign low_lane = wb_sel_in[0];
  assign pointer_wr = req & hit_pointer & wb_we_in & low_lane;
  assign data_wr = req & hit_data & wb_we_in & low_lane;
  assign data_rd = req & hit_data & ~wb_we_in;
  assign wr_byte = wb_dat_in[7:0];

  // Only the low six pointer bits take part in the select
  assign target = pointer[POINTER_SEL_W-1:0];
  assign at_command = (target == REG_COMMAND);
  assign at_result = (target == REG_RESULT);
  // Writes at targets 1..4 reach converters A..D; reads there return results
  assign at_dac = (target >= REG_RESULT) && (target <= REG_INT_TEMP);
  assign dac_channel = 2'(target - REG_RESULT);

  //////////////////////////////////////////////////////////////////////////////
  // Live words

  adc_sample_s cur_sample;
  result_word_s adc_word;
  logic [15:0] ext1_word;
  logic [15:0] ext2_word;
  logic [15:0] int_word;
  logic [15:0] seq_word;
  logic [15:0] live_word;
  logic [7:0] rd_byte;
  logic [31:0] status_word;
  logic [31:0] next_dat;

  // Positions past the last converter channel fall back to channel 0, never off the array
  assign cur_sample = adc_sample_in[3'(cursor) < 3'(ADC_CHANNELS) ? cursor : 3'h0];
  assign adc_word.alert = cur_sample.alert;
  assign adc_word.tag = cursor;
  assign adc_word.value = cur_sample.code;

  assign ext1_word = temp_word(ext1_held, TAG_EXT_TEMP1, 1'b1);
  assign ext2_word = temp_word(ext2_held, TAG_EXT_TEMP2, 1'b1);
  assign int_word = temp_word(int_held, 3'h0, 1'b0);

  // Temperature positions of the sequence replay the held reading, no new conversion
  assign seq_word = (cursor == TAG_EXT_TEMP1) ? ext1_word :
                    (cursor == TAG_EXT_TEMP2) ? ext2_word : adc_word;

  assign live_word = at_result ? seq_word :
                     (target == REG_EXT_TEMP1) ? ext1_word :
                     (target == REG_EXT_TEMP2) ? ext2_word :
                     (target == REG_INT_TEMP) ? int_word : 16'h0000;

  // High byte from the live word, low byte from the copy taken with it
  assign rd_byte = phase ? shadow[7:0] : live_word[15:8];

  assign status_word = status_pack(phase, (command != COMMAND_RESET), cursor);
  assign next_dat = hit_pointer ? {24'h000000, pointer} :
                    hit_status ? status_word :
                    hit_data ? {24'h000000, rd_byte} : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, ack for one cycle

  // Read data holds after the ack so a slow master can still pick it up
  always_comb
  begin
    next_ack = req;
    next_rdata = wb_dat_out;
    if (req)
    begin
      next_rdata = next_dat;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end
    else
    begin
      wb_ack_out <= next_ack;
      wb_dat_out <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pointer and command

  always_comb
  begin
    next_pointer = pointer;
    if (pointer_wr)
    begin
      next_pointer = wr_byte;
    end
  end

  always_comb
  begin
    next_command = command;
    next_cursor = cursor;
    if (data_wr && at_command)
    begin
      next_command = wr_byte;
      next_cursor = next_selected(wr_byte, 3'h7);
    end
    else if (data_rd && at_result && phase)
    begin
      // Step only after the low byte, so both bytes describe one channel
      next_cursor = next_selected(command, cursor);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      pointer <= POINTER_RESET;
      command <= COMMAND_RESET;
      cursor <= 3'h0;
    end
    else
    begin
      pointer <= next_pointer;
      command <= next_command;
      cursor <= next_cursor;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte phase and read copy

  // Pointer write restarts the byte pair; a one-byte command write leaves the phase unchanged
  always_comb
  begin
    next_phase = phase;
    next_shadow = shadow;
    if (pointer_wr)
    begin
      next_phase = 1'b0;
    end
    else if (data_rd)
    begin
      next_phase = ~phase;
      if (!phase)
      begin
        next_shadow = live_word;
      end
    end
    else if (data_wr && !at_command)
    begin
      next_phase = ~phase;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      phase <= 1'b0;
      shadow <= 16'h0000;
    end
    else
    begin
      phase <= next_phase;
      shadow <= next_shadow;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Submodules

  temp_refresh_latch #(
    .PERIOD_CYCLES(TEMP_PERIOD_CYCLES)
  ) u_temp (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ext1_in(ext_temp1_in),
    .ext2_in(ext_temp2_in),
    .int_in(int_temp_in),
    .ext1_out(ext1_held),
    .ext2_out(ext2_held),
    .int_out(int_held),
    .refresh_out(temp_refresh_out)
  );

  dac_code_latch u_dac (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .byte_we_in(data_wr && at_dac),
    .second_byte_in(phase),
    .channel_in(dac_channel),
    .byte_in(wr_byte),
    .dac_code_out(dac_code_out),
    .dac_update_out(dac_update_out)
  );
endmodule

// ---- tb/front_end_model.sv ----
// Front end stand-in: converted samples and temperature readings
`timescale 1ns/1ns
module front_end_model
  import monitor_regs_pkg::*;
(
  input wire logic [7:0] seed_in,
  output adc_sample_s [ADC_CHANNELS-1:0] adc_sample_out,
  output temp_sample_s ext1_out,
  output temp_sample_s ext2_out,
  output temp_sample_s int_out
);
  // Each channel's code has its own top nibble, so a swapped channel shows up
  always_comb
  begin
    for (int i = 0; i < ADC_CHANNELS; i++)
    begin
      adc_sample_out[i] = {seed_in[i], 4'(i + 8), seed_in};
    end
    ext1_out = {1'b1, 1'b0, 3'h5, seed_in};
    ext2_out = {1'b0, 1'b1, 3'h4, seed_in};
    int_out = {1'b1, 1'b1, 3'h3, seed_in};
  end
endmodule

// ---- tb/monitor_regs_assertions.sv ----
// Bus, converter-code and refresh checks for the register bank
`timescale 1ns/1ns
module monitor_regs_assertions
  import monitor_regs_pkg::*;
#(
  parameter int TEMP_PERIOD_CYCLES = 16
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [WB_ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire adc_sample_s [ADC_CHANNELS-1:0] adc_sample_in,
  input wire temp_sample_s ext_temp1_in,
  input wire temp_sample_s ext_temp2_in,
  input wire temp_sample_s int_temp_in,
  input wire logic [DAC_CHANNELS-1:0][CODE_W-1:0] dac_code_out,
  input wire logic [DAC_CHANNELS-1:0] dac_update_out,
  input wire logic temp_refresh_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  int gap;
  logic mapped;
  assign mapped = wb_adr_in inside {WB_POINTER_ADDR, WB_DATA_ADDR, WB_STATUS_ADDR};
  // Cycles since the last refresh pulse
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || temp_refresh_out)
    begin
      gap <= 0;
    end
    else
    begin
      gap <= gap + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  ack_next_edge_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
  ack_has_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack unasked");
  byte_read_a: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0) else $error("wide read");
  unmapped_zero_a: assert property (wb_ack_out && !wb_we_in && !mapped |-> wb_dat_out == 32'h0) else $error("unmapped");
  code_needs_update_a: assert property ($changed(dac_code_out) |-> |dac_update_out) else $error("silent code");
  update_on_write_a: assert property (|dac_update_out |-> $past(wb_we_in && wb_stb_in && wb_adr_in == WB_DATA_ADDR))
    else $error("update without write");
  refresh_pulse_a: assert property (temp_refresh_out |=> !temp_refresh_out) else $error("refresh held");
  refresh_bound_a: assert property (gap <= TEMP_PERIOD_CYCLES + 1) else $error("refresh overdue");
  cover property (|dac_update_out);
  cover property (temp_refresh_out);
  cover property (wb_ack_out && !wb_we_in && wb_adr_in == WB_DATA_ADDR);
endmodule
bind monitor_result_and_dac_regs monitor_regs_assertions #(.TEMP_PERIOD_CYCLES(TEMP_PERIOD_CYCLES)) i_monitor_regs_assertions (.*);

// ---- tb/monitor_result_and_dac_regs_tb_top.sv ----
// Bus-level tests of the result and converter-code register bank
`timescale 1ns/1ns
module monitor_result_and_dac_regs_tb_top;
  import monitor_regs_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] seed = 8'h5a;
  logic [7:0] rd;
  logic [7:0] hold;
  logic [3:0] upd;
  logic refresh;
  int refreshes = 0;
  int mark;
  adc_sample_s [ADC_CHANNELS-1:0] adc;
  temp_sample_s t1, t2, ti;
  logic [3:0][11:0] dac;
  int bad_count = 0;
  int checked = 0;
  int seq [6] = '{0, 1, 4, 6, 7, 0};
  front_end_model i_front_end_model (.seed_in(seed), .adc_sample_out(adc), .ext1_out(t1), .ext2_out(t2), .int_out(ti));
  monitor_result_and_dac_regs #(.TEMP_PERIOD_CYCLES(16)) i_monitor_result_and_dac_regs (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .adc_sample_in(adc),
    .ext_temp1_in(t1), .ext_temp2_in(t2), .int_temp_in(ti), .dac_code_out(dac), .dac_update_out(upd),
    .temp_refresh_out(refresh));
  // Refresh pulses seen, one per pulse
  always @(posedge mclk_in)
  begin
    if (refresh === 1'b1)
    begin
      refreshes <= refreshes + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge mclk_in);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= s;
    @(posedge mclk_in);
    while (ack !== 1'b1)
    begin
      @(posedge mclk_in);
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic rd16(input logic [15:0] exp);
    logic [7:0] hi;
    bus(1'b0, WB_DATA_ADDR, 8'h0, 4'h1);
    hi = rd;
    bus(1'b0, WB_DATA_ADDR, 8'h0, 4'h1);
    chk({hi, rd}, exp);
  endtask
  function automatic logic [15:0] word(input int ch);
    if (ch < 6)
    begin
      return {seed[ch], 3'(ch), 4'(ch + 8), seed};
    end
    return ch == 6 ? {4'he, 1'b0, 3'h5, seed} : {4'h7, 1'b1, 3'h4, seed};
  endfunction
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 mclk_in = ~mclk_in;
  end
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    // Let at least one temperature capture land first
    repeat (40) @(posedge mclk_in);
    bus(1'b1, WB_POINTER_ADDR, 8'h00, 4'h1);
    bus(1'b1, WB_DATA_ADDR, 8'hd3, 4'h1);
    bus(1'b1, WB_POINTER_ADDR, 8'h01, 4'h1);
    foreach (seq[i])
    begin
      rd16(word(seq[i]));
    end
    bus(1'b0, WB_STATUS_ADDR, 8'h0, 4'h1);
    chk(16'(rd), 16'h12);
    bus(1'b1, WB_POINTER_ADDR, 8'hc1, 4'h1);
    bus(1'b0, WB_POINTER_ADDR, 8'h0, 4'h1);
    chk(16'(rd), 16'hc1);
    rd16(word(1));
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, WB_POINTER_ADDR, 8'(k + 2), 4'h1);
      rd16(k == 2 ? {5'h10, 3'h3, seed} : word(k + 6));
    end
    seed <= 8'ha5;
    mark = refreshes;
    repeat (40) @(posedge mclk_in);
    chk(16'(refreshes - mark >= 2 && refreshes - mark <= 3), 16'h1);
    rd16({5'h10, 3'h3, 8'ha5});
    // Lane 0 disabled, so the pointer must keep its value
    bus(1'b1, WB_POINTER_ADDR, 8'h3f, 4'h0);
    bus(1'b0, WB_POINTER_ADDR, 8'h0, 4'h1);
    chk(16'(rd), 16'h04);
    bus(1'b0, 12'h0fc, 8'h0, 4'h1);
    chk(16'(rd), 16'h0);
    // Inputs move between the two bytes; the low byte must still match the high one
    bus(1'b1, WB_POINTER_ADDR, 8'h01, 4'h1);
    bus(1'b0, WB_DATA_ADDR, 8'h0, 4'h1);
    hold = rd;
    seed <= 8'h3c;
    bus(1'b0, WB_DATA_ADDR, 8'h0, 4'h1);
    chk({hold, rd}, 16'h4ca5);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, WB_POINTER_ADDR, 8'(k + 1), 4'h1);
      bus(1'b1, WB_DATA_ADDR, {4'hf, 4'(k + 1)}, 4'h1);
      chk(16'(dac[k]), 16'h0);
      chk(16'(upd), 16'h0);
      bus(1'b1, WB_DATA_ADDR, 8'(8'h3c + k), 4'h1);
      chk(16'(dac[k]), {4'h0, 4'(k + 1), 8'(8'h3c + k)});
      chk(16'(upd), 16'(4'h1 << k));
    end
    finish_test;
  end
endmodule
